// file: core/lfs_top.sv
// Indicator function select with APB configuration register
//
// Decided for this implementation: register access over APB.
module lfs_top #(
  parameter int unsigned STRETCH_30_CYC  = int'(lfs_pkg::STRETCH_30_CYC),
  parameter int unsigned STRETCH_60_CYC  = int'(lfs_pkg::STRETCH_60_CYC),
  parameter int unsigned STRETCH_100_CYC = int'(lfs_pkg::STRETCH_100_CYC),
  parameter int unsigned BLINK_FAST_CYC  = int'(lfs_pkg::BLINK_FAST_CYC),
  parameter int unsigned BLINK_SLOW_CYC  = int'(lfs_pkg::BLINK_SLOW_CYC)
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  // APB slave
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [lfs_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]                pwdata_i,
  input  wire logic [3:0]                 pstrb_i,
  output logic      [31:0]                prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  // Stretch control from the neighbouring fields
  input  wire logic [1:0]                 stretch_period_select_i,
  input  wire logic                       stretch_en_i,
  // Port status, same clock domain
  input  wire logic                       speed_i,
  input  wire logic                       tx_i,
  input  wire logic                       rx_i,
  input  wire logic                       col_i,
  input  wire logic                       link_i,
  input  wire logic                       duplex_i,
  // Indicator drives, high lights the lamp
  output logic                            first_indicator_o,
  output logic                            second_indicator_o
);

  localparam int CW = lfs_pkg::CNT_W;

  lfs_pkg::lfs_sel_t first_sel_reg;
  lfs_pkg::lfs_sel_t second_sel_reg;
  logic [31:0]       prdata_reg;
  logic [1:0]        led_reg;
  logic [1:0]        led_next;
  logic [CW-1:0]     hold_cyc;
  logic [lfs_pkg::NUM_SRC-1:0] evt;
  logic [lfs_pkg::NUM_SRC-1:0] str;
  logic [lfs_pkg::NUM_SRC-1:0] shown;
  logic              blink_fast;
  logic              blink_slow;
  logic              setup;
  logic              access;
  logic              hit_cfg;
  logic              hit_stat;
  logic              cfg_wr;

  // APB decode
  assign setup    = psel_i & ~penable_i;
  assign access   = psel_i & penable_i;
  assign hit_cfg  = paddr_i == lfs_pkg::CFG_OFFSET;
  assign hit_stat = paddr_i == lfs_pkg::STAT_OFFSET;
  assign cfg_wr   = access & pwrite_i & hit_cfg & pstrb_i[1];

  assign pready_o  = 1'b1;
  assign pslverr_o = access & ~(hit_cfg | hit_stat);
  assign prdata_o  = prdata_reg;

  // Select fields, written through byte lane 1
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      first_sel_reg  <= lfs_pkg::lfs_sel_t'(lfs_pkg::FIRST_RST);
      second_sel_reg <= lfs_pkg::lfs_sel_t'(lfs_pkg::SECOND_RST);
    end else if (cfg_wr) begin
      first_sel_reg  <= lfs_pkg::lfs_sel_t'(pwdata_i[lfs_pkg::FIRST_LSB +: lfs_pkg::SEL_W]);
      second_sel_reg <= lfs_pkg::lfs_sel_t'(pwdata_i[lfs_pkg::SECOND_LSB +: lfs_pkg::SEL_W]);
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup) begin
      prdata_reg <= 32'h0000_0000;
      if (hit_cfg) begin
        prdata_reg[lfs_pkg::FIRST_LSB +: lfs_pkg::SEL_W]  <= first_sel_reg;
        prdata_reg[lfs_pkg::SECOND_LSB +: lfs_pkg::SEL_W] <= second_sel_reg;
      end else if (hit_stat) begin
        prdata_reg[lfs_pkg::STAT_FIRST_BIT]  <= led_reg[0];
        prdata_reg[lfs_pkg::STAT_SECOND_BIT] <= led_reg[1];
        prdata_reg[lfs_pkg::STAT_ACT_LSB +: lfs_pkg::NUM_SRC] <= str;
      end
    end
  end

  // Stretch period; reserved code falls back to the shortest
  always_comb begin
    unique case (lfs_pkg::lfs_period_t'(stretch_period_select_i))
      lfs_pkg::PER_60:  hold_cyc = CW'(STRETCH_60_CYC);
      lfs_pkg::PER_100: hold_cyc = CW'(STRETCH_100_CYC);
      default:          hold_cyc = CW'(STRETCH_30_CYC);
    endcase
  end

  assign evt[lfs_pkg::SRC_TX]  = tx_i;
  assign evt[lfs_pkg::SRC_RX]  = rx_i;
  assign evt[lfs_pkg::SRC_COL] = col_i;
  assign evt[lfs_pkg::SRC_ACT] = tx_i | rx_i;

  // One stretcher per event source
  for (genvar g = 0; g < lfs_pkg::NUM_SRC; g++) begin : g_src
    lfs_stretch #(
      .CW (CW)
    ) u_stretch (
      .clk_i      (clk_i),
      .rst_n_i    (rst_n_i),
      .event_i    (evt[g]),
      .hold_cyc_i (hold_cyc),
      .active_o   (str[g])
    );
    // Single sources stretch only when enabled
    assign shown[g] = stretch_en_i ? str[g] : evt[g];
  end

  lfs_blink #(
    .CW       (CW),
    .HALF_CYC (BLINK_FAST_CYC)
  ) u_fast (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .blink_o (blink_fast)
  );

  lfs_blink #(
    .CW       (CW),
    .HALF_CYC (BLINK_SLOW_CYC)
  ) u_slow (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .blink_o (blink_slow)
  );

  // Source selection for one indicator
  function automatic logic pick(
    input lfs_pkg::lfs_sel_t           sel,
    input logic [lfs_pkg::NUM_SRC-1:0] sh,
    input logic [lfs_pkg::NUM_SRC-1:0] st,
    input logic                        spd,
    input logic                        lnk,
    input logic                        dup,
    input logic                        fast,
    input logic                        slow
  );
    logic r;
    r = 1'b0;
    unique case (sel)
      lfs_pkg::SEL_SPEED:    r = spd;
      lfs_pkg::SEL_TX:       r = sh[lfs_pkg::SRC_TX];
      lfs_pkg::SEL_RX:       r = sh[lfs_pkg::SRC_RX];
      lfs_pkg::SEL_COL:      r = sh[lfs_pkg::SRC_COL];
      lfs_pkg::SEL_LINK:     r = lnk;
      lfs_pkg::SEL_DUPLEX:   r = dup;
      lfs_pkg::SEL_ACT:      r = sh[lfs_pkg::SRC_ACT];
      lfs_pkg::SEL_ON:       r = 1'b1;
      lfs_pkg::SEL_OFF:      r = 1'b0;
      lfs_pkg::SEL_FAST:     r = fast;
      lfs_pkg::SEL_SLOW:     r = slow;
      lfs_pkg::SEL_LINK_RX:  r = lnk & ~(st[lfs_pkg::SRC_RX] & fast);
      lfs_pkg::SEL_LINK_ACT: r = st[lfs_pkg::SRC_ACT] ? fast : lnk;
      lfs_pkg::SEL_DUP_COL:  r = st[lfs_pkg::SRC_COL] ? fast : dup;
      default:               r = 1'b0;
    endcase
    return r;
  endfunction

  always_comb begin
    led_next[0] = pick(first_sel_reg, shown, str, speed_i, link_i, duplex_i, blink_fast, blink_slow);
    led_next[1] = pick(second_sel_reg, shown, str, speed_i, link_i, duplex_i, blink_fast, blink_slow);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      led_reg <= 2'h0;
    end else begin
      led_reg <= led_next;
    end
  end

  assign first_indicator_o  = led_reg[0];
  assign second_indicator_o = led_reg[1];

  // Checks
  a_first_reset: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(!rst_n_i) |-> first_sel_reg == lfs_pkg::SEL_SPEED)
    else $error("first select not speed after reset");

  a_second_reset: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(!rst_n_i) |-> second_sel_reg == lfs_pkg::SEL_LINK)
    else $error("second select not link after reset");

  a_cfg_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cfg_wr |=> first_sel_reg == $past(pwdata_i[15:12]) && second_sel_reg == $past(pwdata_i[11:8]))
    else $error("select write lost");

  a_tx_stretch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (first_sel_reg == lfs_pkg::SEL_TX && stretch_en_i && tx_i) ##1
    (first_sel_reg == lfs_pkg::SEL_TX && stretch_en_i && !tx_i) |=> first_indicator_o)
    else $error("transmit event not stretched");

  a_col_raw: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (first_sel_reg == lfs_pkg::SEL_COL && !stretch_en_i) |=> first_indicator_o == $past(col_i))
    else $error("collision not shown raw");

  a_duplex_show: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    second_sel_reg == lfs_pkg::SEL_DUPLEX |=> second_indicator_o == $past(duplex_i))
    else $error("duplex not shown");

  a_test_on: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    first_sel_reg == lfs_pkg::SEL_ON [*2] |-> first_indicator_o)
    else $error("forced on not lit");

  a_test_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    second_sel_reg == lfs_pkg::SEL_OFF [*2] |-> !second_indicator_o)
    else $error("forced off lit");

  a_link_rx: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (first_sel_reg == lfs_pkg::SEL_LINK_RX && link_i && !str[lfs_pkg::SRC_RX]) |=> first_indicator_o)
    else $error("link up not solid");

  a_act_nolink: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (first_sel_reg == lfs_pkg::SEL_LINK_ACT && str[lfs_pkg::SRC_ACT]) |=> first_indicator_o == $past(blink_fast))
    else $error("activity not blinking");

  a_dup_col: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (second_sel_reg == lfs_pkg::SEL_DUP_COL && !str[lfs_pkg::SRC_COL]) |=> second_indicator_o == $past(duplex_i))
    else $error("duplex not solid");

  a_comb_stretch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!stretch_en_i && col_i) ##1 !col_i |-> str[lfs_pkg::SRC_COL])
    else $error("combined source not stretched");

  a_unused_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (second_sel_reg == lfs_pkg::SEL_UNUSED6 || second_sel_reg == lfs_pkg::SEL_UNUSEDF) |=> !second_indicator_o)
    else $error("unused code lit");

  a_unmapped_err: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (access && !hit_cfg && !hit_stat) |-> pslverr_o && pready_o)
    else $error("unmapped access not flagged");

  c_tx_stretch: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    first_sel_reg == lfs_pkg::SEL_TX && tx_i ##1 !tx_i && first_indicator_o);

  c_link_act: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    first_sel_reg == lfs_pkg::SEL_LINK_ACT && str[lfs_pkg::SRC_ACT] && !link_i);

  c_cfg_write: cover property (@(posedge clk_i) disable iff (!rst_n_i) cfg_wr);

  c_stat_read: cover property (@(posedge clk_i) disable iff (!rst_n_i) access && !pwrite_i && hit_stat);

endmodule

// file: shared/lfs_pkg.sv
// Constants, field layout and codes for the indicator function select block
package lfs_pkg;

  // Register byte addresses
  localparam logic [7:0] CFG_OFFSET  = 8'h14;
  localparam logic [7:0] STAT_OFFSET = 8'h18;
  localparam int         ADDR_W      = 8;

  // Configuration register fields
  localparam int         SEL_W      = 4;
  localparam int         FIRST_LSB  = 12;
  localparam int         SECOND_LSB = 8;
  localparam logic [3:0] FIRST_RST  = 4'h0;
  localparam logic [3:0] SECOND_RST = 4'h4;

  // Status register fields
  localparam int STAT_FIRST_BIT  = 0;
  localparam int STAT_SECOND_BIT = 1;
  localparam int STAT_ACT_LSB    = 2;

  // Timing
  localparam longint unsigned CLK_HZ        = 25_000_000;
  localparam longint unsigned STRETCH_30_MS  = 30;
  localparam longint unsigned STRETCH_60_MS  = 60;
  localparam longint unsigned STRETCH_100_MS = 100;
  localparam longint unsigned BLINK_FAST_MS  = 50;
  localparam longint unsigned BLINK_SLOW_MS  = 250;
  localparam longint unsigned STRETCH_30_CYC  = STRETCH_30_MS * CLK_HZ / 1000;
  localparam longint unsigned STRETCH_60_CYC  = STRETCH_60_MS * CLK_HZ / 1000;
  localparam longint unsigned STRETCH_100_CYC = STRETCH_100_MS * CLK_HZ / 1000;
  localparam longint unsigned BLINK_FAST_CYC  = BLINK_FAST_MS * CLK_HZ / 1000;
  localparam longint unsigned BLINK_SLOW_CYC  = BLINK_SLOW_MS * CLK_HZ / 1000;
  localparam int              CNT_W           = 24;

  // Stretched event sources
  localparam int SRC_TX  = 0;
  localparam int SRC_RX  = 1;
  localparam int SRC_COL = 2;
  localparam int SRC_ACT = 3;
  localparam int NUM_SRC = 4;

  typedef enum logic [3:0] {
    SEL_SPEED    = 4'h0,
    SEL_TX       = 4'h1,
    SEL_RX       = 4'h2,
    SEL_COL      = 4'h3,
    SEL_LINK     = 4'h4,
    SEL_DUPLEX   = 4'h5,
    SEL_UNUSED6  = 4'h6,
    SEL_ACT      = 4'h7,
    SEL_ON       = 4'h8,
    SEL_OFF      = 4'h9,
    SEL_FAST     = 4'hA,
    SEL_SLOW     = 4'hB,
    SEL_LINK_RX  = 4'hC,
    SEL_LINK_ACT = 4'hD,
    SEL_DUP_COL  = 4'hE,
    SEL_UNUSEDF  = 4'hF
  } lfs_sel_t;

  typedef enum logic [1:0] {
    PER_30   = 2'h0,
    PER_60   = 2'h1,
    PER_100  = 2'h2,
    PER_RSVD = 2'h3
  } lfs_period_t;

endpackage

// file: core/lfs_stretch.sv
// Pulse stretcher holding an event for a loadable number of cycles
module lfs_stretch #(
  parameter int CW = 24
) (
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          event_i,
  input  wire logic [CW-1:0] hold_cyc_i,
  output logic               active_o
);

  logic [CW-1:0] cnt_reg;

  // Reload while the event lasts, then count down
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
    end else if (event_i) begin
      cnt_reg <= hold_cyc_i;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  assign active_o = event_i | (cnt_reg != '0);

  a_hold_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    event_i |=> cnt_reg == $past(hold_cyc_i))
    else $error("stretch count not loaded");

  a_hold_count: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!event_i && cnt_reg > 1) |=> active_o && cnt_reg == $past(cnt_reg) - 1'b1)
    else $error("stretch count did not step down");

endmodule

// file: core/lfs_blink.sv
// Free running square wave for the blink patterns
module lfs_blink #(
  parameter int          CW       = 24,
  parameter int unsigned HALF_CYC = 1250000
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  output logic      blink_o
);

  localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

  logic [CW-1:0] cnt_reg;
  logic          blink_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg   <= '0;
      blink_reg <= 1'b0;
    end else if (cnt_reg >= LAST) begin
      cnt_reg   <= '0;
      blink_reg <= ~blink_reg;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign blink_o = blink_reg;

endmodule

// file: testbench/lfs_top_tb_top.sv
// Self-checking bench for the indicator function select block
module lfs_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int P30 = 10;

  logic                       clk_i                   = 1'b0;
  logic                       rst_n_i                 = 1'b0;
  logic                       psel_i                  = 1'b0;
  logic                       penable_i               = 1'b0;
  logic                       pwrite_i                = 1'b0;
  logic [lfs_pkg::ADDR_W-1:0] paddr_i                 = 8'h00;
  logic [31:0]                pwdata_i                = 32'h0;
  logic [3:0]                 pstrb_i                 = 4'h0;
  logic [1:0]                 stretch_period_select_i = 2'h0;
  logic                       stretch_en_i            = 1'b1;
  logic                       speed_i                 = 1'b1;
  logic                       tx_i                    = 1'b0;
  logic                       rx_i                    = 1'b0;
  logic                       col_i                   = 1'b0;
  logic                       link_i                  = 1'b1;
  logic                       duplex_i                = 1'b0;
  logic [31:0]                prdata_o;
  logic                       pready_o;
  logic                       pslverr_o;
  logic                       first_indicator_o;
  logic                       second_indicator_o;
  int                         miscompares             = 0;
  int                         checked                 = 0;

  lfs_top #(.STRETCH_30_CYC(P30), .STRETCH_60_CYC(20), .STRETCH_100_CYC(30),
            .BLINK_FAST_CYC(4), .BLINK_SLOW_CYC(8)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .stretch_period_select_i(stretch_period_select_i), .stretch_en_i(stretch_en_i),
    .speed_i(speed_i), .tx_i(tx_i), .rx_i(rx_i), .col_i(col_i), .link_i(link_i), .duplex_i(duplex_i),
    .first_indicator_o(first_indicator_o), .second_indicator_o(second_indicator_o));

  always #20 clk_i = ~clk_i;

  task automatic test_done();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // One APB transfer, waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [31:0] exp, input logic err);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= d;
    pstrb_i   <= s;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) begin
      miscompares++;
      test_done();
    end
    if (!wr) chk(prdata_o, exp, "read data");
    chk({31'h0, pslverr_o}, {31'h0, err}, "slave error");
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic sel(input logic [3:0] a, input logic [3:0] b);
    apb(1'b1, lfs_pkg::CFG_OFFSET, {16'h0, a, b, 8'h00}, 4'hF, 32'h0, 1'b0);
    repeat (2) @(posedge clk_i);
  endtask

  task automatic led(input logic e1, input logic e2, input string w);
    @(negedge clk_i);
    chk({31'h0, first_indicator_o}, {31'h0, e1}, w);
    chk({31'h0, second_indicator_o}, {31'h0, e2}, w);
  endtask

  function automatic logic steady(input logic [3:0] c, input logic s, input logic l, input logic d);
    case (c)
      4'h0: return s;
      4'h4, 4'hC, 4'hD: return l;
      4'h5, 4'hE: return d;
      4'h8: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Pulse one event on a combined code and expect a blink, then the steady level
  task automatic combo(input logic [3:0] c, input logic [2:0] ev, input logic st);
    int hits;
    hits = 0;
    sel(c, c);
    @(posedge clk_i);
    {tx_i, rx_i, col_i} <= ev;
    @(posedge clk_i);
    {tx_i, rx_i, col_i} <= 3'b000;
    repeat (P30) begin
      @(negedge clk_i);
      if (first_indicator_o !== st) hits++;
    end
    chk({31'h0, hits != 0}, 32'h1, "combined blink");
    repeat (2 * P30) @(posedge clk_i);
    led(st, st, "combined steady");
  endtask

  initial begin
    repeat (100000) @(posedge clk_i);
    miscompares++;
    test_done();
  end

  initial begin
    int n1;
    int n2;
    int per;
    logic p1;
    logic p2;
    logic [3:0] code [4];
    code = '{4'h1, 4'h2, 4'h3, 4'h7};
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    // Edge of release still resets the indicator register
    @(posedge clk_i);
    led(1'b1, 1'b1, "reset sources");
    apb(1'b0, lfs_pkg::STAT_OFFSET, 32'h0, 4'hF, 32'h0000_0003, 1'b0);
    apb(1'b1, lfs_pkg::STAT_OFFSET, 32'hFFFF_FFFF, 4'hF, 32'h0, 1'b0);
    apb(1'b0, lfs_pkg::CFG_OFFSET, 32'h0, 4'hF, 32'h0000_0400, 1'b0);
    apb(1'b1, lfs_pkg::CFG_OFFSET, 32'h0000_9A00, 4'hD, 32'h0, 1'b0);
    apb(1'b0, lfs_pkg::CFG_OFFSET, 32'h0, 4'hF, 32'h0000_0400, 1'b0);
    apb(1'b1, lfs_pkg::CFG_OFFSET, 32'hFFFF_5A00, 4'hF, 32'h0, 1'b0);
    apb(1'b0, lfs_pkg::CFG_OFFSET, 32'h0, 4'hF, 32'h0000_5A00, 1'b0);
    apb(1'b0, 8'h20, 32'h0, 4'hF, 32'h0, 1'b1);
    $display("test registers done");
    for (int v = 0; v < 2; v++) begin
      @(posedge clk_i);
      speed_i  <= ~v[0];
      link_i   <= v[0];
      duplex_i <= ~v[0];
      for (int c = 0; c < 16; c++) begin
        if (c != 10 && c != 11) begin
          sel(c[3:0], c[3:0]);
          p1 = steady(c[3:0], ~v[0], v[0], ~v[0]);
          led(p1, p1, "steady code");
        end
      end
    end
    $display("test steady codes done");
    for (int i = 0; i < 4; i++) begin
      per = (i == 1) ? 20 : (i == 2) ? 30 : P30;
      sel(code[i], 4'h9);
      @(posedge clk_i);
      stretch_period_select_i <= i[1:0];
      stretch_en_i            <= 1'b1;
      @(posedge clk_i);
      tx_i  <= (i == 0 || i == 3);
      rx_i  <= (i == 1);
      col_i <= (i == 2);
      @(posedge clk_i);
      {tx_i, rx_i, col_i} <= 3'b000;
      // Last lit cycle, then dark at the very next one
      repeat (per) @(posedge clk_i);
      led(1'b1, 1'b0, "stretch held");
      led(1'b0, 1'b0, "stretch ended");
    end
    $display("test stretch done");
    @(posedge clk_i);
    stretch_period_select_i <= 2'h0;
    stretch_en_i            <= 1'b0;
    link_i                  <= 1'b0;
    duplex_i                <= 1'b0;
    combo(4'hD, 3'b100, 1'b0);
    @(posedge clk_i);
    link_i <= 1'b1;
    combo(4'hC, 3'b010, 1'b1);
    @(posedge clk_i);
    duplex_i <= 1'b1;
    combo(4'hE, 3'b001, 1'b1);
    // Single source with stretching off shows the bare event
    sel(4'h3, 4'h9);
    @(posedge clk_i);
    col_i <= 1'b1;
    @(posedge clk_i);
    col_i <= 1'b0;
    led(1'b1, 1'b0, "raw event");
    led(1'b0, 1'b0, "raw event gone");
    $display("test combined done");
    sel(4'hA, 4'hB);
    n1 = 0;
    n2 = 0;
    @(negedge clk_i);
    p1 = first_indicator_o;
    p2 = second_indicator_o;
    repeat (48) begin
      @(negedge clk_i);
      if (first_indicator_o !== p1) n1++;
      if (second_indicator_o !== p2) n2++;
      p1 = first_indicator_o;
      p2 = second_indicator_o;
    end
    chk({31'h0, n1 >= 11 && n1 <= 12}, 32'h1, "fast blink");
    chk({31'h0, n2 >= 5 && n2 <= 6}, 32'h1, "slow blink");
    $display("test blink done");
    test_done();
  end
endmodule
